//--- common/skip_pkg.sv
// Shared constants for the skip, table read and arithmetic execution block
package skip_pkg;
  // Operation codes presented on the operation port
  localparam logic [4:0] OP_SET_BYTE = 5'h00;
  localparam logic [4:0] OP_SET_BIT = 5'h01;
  localparam logic [4:0] OP_INC_SKIP = 5'h02;
  localparam logic [4:0] OP_INC_ACC_SKIP = 5'h03;
  localparam logic [4:0] OP_SKIP_BIT_SET = 5'h04;
  localparam logic [4:0] OP_SKIP_ZERO = 5'h05;
  localparam logic [4:0] OP_LOAD_ACC_SKIP = 5'h06;
  localparam logic [4:0] OP_SKIP_BIT_CLR = 5'h07;
  localparam logic [4:0] OP_SUB_ACC = 5'h08;
  localparam logic [4:0] OP_SUB_MEM = 5'h09;
  localparam logic [4:0] OP_SUB_IMM = 5'h0A;
  localparam logic [4:0] OP_SWAP_MEM = 5'h0B;
  localparam logic [4:0] OP_SWAP_ACC = 5'h0C;
  localparam logic [4:0] OP_TBL_CUR = 5'h0D;
  localparam logic [4:0] OP_TBL_LAST = 5'h0E;
  localparam logic [4:0] OP_XOR_ACC = 5'h0F;
  localparam logic [4:0] OP_XOR_MEM = 5'h10;
  localparam logic [4:0] OP_XOR_IMM = 5'h11;

  // Register port offsets
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_FLAGS = 3'h1;
  localparam logic [2:0] REG_LOOKUP_PTR = 3'h2;
  localparam logic [2:0] REG_UPPER = 3'h3;
  localparam logic [2:0] REG_MEM_INDEX = 3'h4;
  localparam logic [2:0] REG_MEM_DATA = 3'h5;

  // Flag field positions
  localparam int FLAG_C = 0;
  localparam int FLAG_HALF_CARRY = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_SIGN_ERR = 3;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UPPER_RESET = 8'h00;
  localparam logic [6:0] INDEX_RESET = 7'h00;

  // Data and program memory shape
  localparam int DMEM_WORDS = 128;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [2:0] LAST_PAGE = 3'h7;
endpackage

//--- verilog/skip_logic_table_read_ops.sv
// Execution unit for set, skip, subtract, swap, table read and xor operations
`timescale 1ns/1ns
`default_nettype none
module skip_logic_table_read_ops (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Operation port
  input wire logic OP_VALID_IN,
  input wire logic [4:0] OP_CODE_IN,
  input wire logic [6:0] OP_ADDR_IN,
  input wire logic [2:0] OP_BIT_IN,
  input wire logic [7:0] OP_IMM_IN,
  input wire logic [2:0] OP_PAGE_IN,
  output logic OP_READY_OUT,
  output logic OP_DONE_OUT,
  output logic OP_SKIP_OUT,
  // Program memory read port
  output logic [10:0] ROM_ADDR_OUT,
  input wire logic [15:0] ROM_DATA_IN,
  // Register port
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Visible core state
  output logic [7:0] ACC_OUT,
  output logic [3:0] FLAGS_OUT
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_ROM
  } state_e;

  typedef struct packed {
    state_e st;
    logic [7:0] acc;
    logic [3:0] flags;
    logic [7:0] ptr;
    logic [7:0] upper;
    logic [6:0] idx;
    logic [7:0] rdata;
    logic ready;
    logic done;
    logic skip;
    logic [10:0] rom_addr;
    logic [6:0] dest;
  } core_s;

  core_s state_reg;
  core_s state_next;
  // Operand and table destination storage
  logic [7:0] dmem [skip_pkg::DMEM_WORDS];
  // One write port shared by register and operation writes
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;

  // Eight-bit increment with wrap
  function automatic logic [7:0] inc_byte(input logic [7:0] v);
    return v + 8'h01;
  endfunction

  // Whole byte equals zero
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // Selected bit of a byte
  function automatic logic bit_of(input logic [7:0] v, input logic [2:0] i);
    return v[i];
  endfunction

  // Subtraction as a plus inverted b plus one; returns {sign error, half carry, carry, result}
  function automatic logic [10:0] sub_calc(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    logic sign_err;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    sign_err = (a[7] != b[7]) && (full[7] != a[7]);
    return {sign_err, low[4], full[8], full[7:0]};
  endfunction

  // Flags after a subtraction
  // Carry set means no borrow
  function automatic logic [3:0] sub_flags(input logic [10:0] s);
    logic [3:0] f;
    f = 4'h0;
    f[skip_pkg::FLAG_C] = s[8];
    f[skip_pkg::FLAG_HALF_CARRY] = s[9];
    f[skip_pkg::FLAG_Z] = is_zero(s[7:0]);
    f[skip_pkg::FLAG_SIGN_ERR] = s[10];
    return f;
  endfunction

  // Zero flag replaced, others kept
  function automatic logic [3:0] z_only(input logic [3:0] f, input logic [7:0] res);
    logic [3:0] o;
    o = f;
    o[skip_pkg::FLAG_Z] = is_zero(res);
    return o;
  endfunction

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  always_comb begin
    logic [7:0] m;
    logic [7:0] res;
    logic [10:0] s;
    logic take;
    logic reg_we;
    // Operand byte is read combinationally in the take cycle
    m = dmem[OP_ADDR_IN];
    res = 8'h00;
    s = 11'h000;
    take = 1'b0;
    reg_we = 1'b0;
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.skip = 1'b0;
    mem_we = 1'b0;
    mem_wa = state_reg.idx;
    mem_wd = REG_WDATA_IN;
    // Register port; an operation in the same cycle overrides it
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        skip_pkg::REG_ACC: state_next.acc = REG_WDATA_IN;
        skip_pkg::REG_FLAGS: state_next.flags = REG_WDATA_IN[3:0];
        skip_pkg::REG_LOOKUP_PTR: state_next.ptr = REG_WDATA_IN;
        skip_pkg::REG_MEM_INDEX: state_next.idx = REG_WDATA_IN[6:0];
        skip_pkg::REG_MEM_DATA: reg_we = 1'b1;
        // Upper byte register is read-only
        default: ;
      endcase
    end

    // Register read-back, answered one cycle after the strobe
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        skip_pkg::REG_ACC: state_next.rdata = state_reg.acc;
        skip_pkg::REG_FLAGS: state_next.rdata = {4'h0, state_reg.flags};
        skip_pkg::REG_LOOKUP_PTR: state_next.rdata = state_reg.ptr;
        skip_pkg::REG_UPPER: state_next.rdata = state_reg.upper;
        skip_pkg::REG_MEM_INDEX: state_next.rdata = {1'b0, state_reg.idx};
        skip_pkg::REG_MEM_DATA: state_next.rdata = dmem[state_reg.idx];
        default: state_next.rdata = 8'h00;
      endcase
    end

    // Operation decode
    unique case (state_reg.st)
      ST_IDLE: begin
        if (OP_VALID_IN) begin
          unique case (OP_CODE_IN)
            skip_pkg::OP_SET_BYTE: begin
              mem_we = 1'b1;
              mem_wd = skip_pkg::ALL_ONES;
            end
            skip_pkg::OP_SET_BIT: begin
              res = m;
              res[OP_BIT_IN] = 1'b1;
              mem_we = 1'b1;
              mem_wd = res;
            end
            skip_pkg::OP_INC_SKIP: begin
              res = inc_byte(m);
              mem_we = 1'b1;
              mem_wd = res;
              take = is_zero(res);
            end
            skip_pkg::OP_INC_ACC_SKIP: begin
              res = inc_byte(m);
              state_next.acc = res;
              take = is_zero(res);
            end
            skip_pkg::OP_SKIP_BIT_SET: take = bit_of(m, OP_BIT_IN);
            skip_pkg::OP_SKIP_ZERO: take = is_zero(m);
            skip_pkg::OP_LOAD_ACC_SKIP: begin
              state_next.acc = m;
              take = is_zero(m);
            end
            skip_pkg::OP_SKIP_BIT_CLR: take = !bit_of(m, OP_BIT_IN);
            skip_pkg::OP_SUB_ACC: begin
              s = sub_calc(state_reg.acc, m);
              state_next.acc = s[7:0];
              state_next.flags = sub_flags(s);
            end
            skip_pkg::OP_SUB_MEM: begin
              s = sub_calc(state_reg.acc, m);
              mem_we = 1'b1;
              mem_wd = s[7:0];
              state_next.flags = sub_flags(s);
            end
            skip_pkg::OP_SUB_IMM: begin
              s = sub_calc(state_reg.acc, OP_IMM_IN);
              state_next.acc = s[7:0];
              state_next.flags = sub_flags(s);
            end
            skip_pkg::OP_SWAP_MEM: begin
              mem_we = 1'b1;
              mem_wd = swap_nib(m);
            end
            skip_pkg::OP_SWAP_ACC: state_next.acc = swap_nib(m);
            // Ready drops until the program word has been stored
            skip_pkg::OP_TBL_CUR: begin
              state_next.rom_addr = {OP_PAGE_IN, state_reg.ptr};
              state_next.dest = OP_ADDR_IN;
              state_next.st = ST_ROM;
              state_next.ready = 1'b0;
            end
            skip_pkg::OP_TBL_LAST: begin
              state_next.rom_addr = {skip_pkg::LAST_PAGE, state_reg.ptr};
              state_next.dest = OP_ADDR_IN;
              state_next.st = ST_ROM;
              state_next.ready = 1'b0;
            end
            skip_pkg::OP_XOR_ACC: begin
              res = state_reg.acc ^ m;
              state_next.acc = res;
              state_next.flags = z_only(state_reg.flags, res);
            end
            skip_pkg::OP_XOR_MEM: begin
              res = state_reg.acc ^ m;
              mem_we = 1'b1;
              mem_wd = res;
              state_next.flags = z_only(state_reg.flags, res);
            end
            skip_pkg::OP_XOR_IMM: begin
              res = state_reg.acc ^ OP_IMM_IN;
              state_next.acc = res;
              state_next.flags = z_only(state_reg.flags, res);
            end
            default: ;
          endcase
          // Operation writes go to the operand address
          if (mem_we) begin
            mem_wa = OP_ADDR_IN;
          end
          if (take) begin
            // Fetched successor is discarded during one dummy cycle
            state_next.st = ST_DUMMY;
            state_next.ready = 1'b0;
          end else if (state_next.st == ST_IDLE) begin
            state_next.done = 1'b1;
          end
        end
      end
      ST_DUMMY: begin
        // Successor slot: report done together with the skip
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
        state_next.done = 1'b1;
        state_next.skip = 1'b1;
      end
      ST_ROM: begin
        // Program word answers the address registered at the take edge
        mem_we = 1'b1;
        mem_wa = state_reg.dest;
        mem_wd = ROM_DATA_IN[7:0];
        state_next.upper = ROM_DATA_IN[15:8];
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
        state_next.done = 1'b1;
      end
      // Unused state code returns to idle
      default: begin
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
      end
    endcase

    // Register write to memory yields to an operation write in the same cycle
    mem_we = mem_we || reg_we;
  end

  always_ff @(posedge CLK_IN) begin
    // Synchronous reset; ready stays high so an operation can follow at once
    if (RST_IN) begin
      state_reg.st <= ST_IDLE;
      state_reg.acc <= skip_pkg::ACC_RESET;
      state_reg.flags <= skip_pkg::FLAGS_RESET;
      state_reg.ptr <= skip_pkg::PTR_RESET;
      state_reg.upper <= skip_pkg::UPPER_RESET;
      state_reg.idx <= skip_pkg::INDEX_RESET;
      state_reg.rdata <= 8'h00;
      state_reg.ready <= 1'b1;
      state_reg.done <= 1'b0;
      state_reg.skip <= 1'b0;
      state_reg.rom_addr <= 11'h000;
      state_reg.dest <= 7'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Data memory holds contents across reset
  always_ff @(posedge CLK_IN) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  // Every output is a state register field
  assign OP_READY_OUT = state_reg.ready;
  assign OP_DONE_OUT = state_reg.done;
  assign OP_SKIP_OUT = state_reg.skip;
  assign ROM_ADDR_OUT = state_reg.rom_addr;
  assign REG_RDATA_OUT = state_reg.rdata;
  assign ACC_OUT = state_reg.acc;
  assign FLAGS_OUT = state_reg.flags;

endmodule
`default_nettype wire

//--- test/skip_logic_table_read_ops_chk.sv
// Port-level assertions for the skip, table read and arithmetic unit
`timescale 1ns/1ns
`default_nettype none
module skip_logic_table_read_ops_chk (
  // Clock, reset and request
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic OP_VALID_IN,
  input wire logic [4:0] OP_CODE_IN,
  input wire logic [7:0] OP_IMM_IN,
  input wire logic [2:0] OP_PAGE_IN,
  // Observed outputs
  input wire logic OP_READY_OUT,
  input wire logic OP_DONE_OUT,
  input wire logic OP_SKIP_OUT,
  input wire logic [10:0] ROM_ADDR_OUT,
  input wire logic [7:0] ACC_OUT,
  input wire logic [3:0] FLAGS_OUT
);
  wire tk = OP_VALID_IN & OP_READY_OUT;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence take(logic [4:0] c);
    tk && OP_CODE_IN == c;
  endsequence
  sequence one_done;
    OP_DONE_OUT && !OP_SKIP_OUT;
  endsequence
  sequence two_done;
    !OP_DONE_OUT ##1 one_done;
  endsequence
  AST_SKIP_DUMMY: assert property (OP_SKIP_OUT |-> OP_DONE_OUT && !$past(OP_READY_OUT))
    else $error("skip pulse without done or dummy cycle");
  AST_SET_BYTE: assert property (take(skip_pkg::OP_SET_BYTE) |=> one_done ##0 $stable(FLAGS_OUT))
    else $error("byte set timing or flags wrong");
  AST_TBL_TIME: assert property (take(skip_pkg::OP_TBL_CUR) or take(skip_pkg::OP_TBL_LAST) |=> two_done)
    else $error("table read not two cycles");
  AST_TBL_PAGE: assert property (take(skip_pkg::OP_TBL_CUR) |=> ROM_ADDR_OUT[10:8] == $past(OP_PAGE_IN))
    else $error("table read page wrong");
  AST_TBL_LAST: assert property (take(skip_pkg::OP_TBL_LAST) |=> ROM_ADDR_OUT[10:8] == skip_pkg::LAST_PAGE)
    else $error("last page read page wrong");
  AST_SUB_IMM: assert property (take(skip_pkg::OP_SUB_IMM) |=> ACC_OUT == $past(ACC_OUT) - $past(OP_IMM_IN)
    && FLAGS_OUT[skip_pkg::FLAG_C] == ($past(ACC_OUT) >= $past(OP_IMM_IN))) else $error("subtract result wrong");
  AST_SUB_ZERO: assert property (take(skip_pkg::OP_SUB_IMM) |=> FLAGS_OUT[skip_pkg::FLAG_Z] == (ACC_OUT == 8'h00))
    else $error("zero flag wrong");
  AST_XOR_IMM: assert property (take(skip_pkg::OP_XOR_IMM) |=> ACC_OUT == ($past(ACC_OUT) ^ $past(OP_IMM_IN)))
    else $error("xor result wrong");
  AST_XOR_KEEP: assert property (take(skip_pkg::OP_XOR_IMM) |=> (FLAGS_OUT & 4'hB) == ($past(FLAGS_OUT) & 4'hB))
    else $error("xor touched other flags");
  AST_SWAP_FLAGS: assert property (take(skip_pkg::OP_SWAP_ACC) |=> $stable(FLAGS_OUT))
    else $error("swap touched flags");
endmodule
bind skip_logic_table_read_ops skip_logic_table_read_ops_chk chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .OP_VALID_IN(OP_VALID_IN), .OP_CODE_IN(OP_CODE_IN), .OP_IMM_IN(OP_IMM_IN), .OP_PAGE_IN(OP_PAGE_IN),
  .OP_READY_OUT(OP_READY_OUT), .OP_DONE_OUT(OP_DONE_OUT), .OP_SKIP_OUT(OP_SKIP_OUT),
  .ROM_ADDR_OUT(ROM_ADDR_OUT), .ACC_OUT(ACC_OUT), .FLAGS_OUT(FLAGS_OUT));
`default_nettype wire

//--- test/skip_logic_table_read_ops_bench.sv
// Self-checking bench for the skip, table read and arithmetic unit
`timescale 1ns/1ns
`default_nettype none
module skip_logic_table_read_ops_bench;
  logic clk = 1'b0, rst = 1'b1, v = 1'b0, wr = 1'b0, rd = 1'b0, rdy, done, skp;
  logic [4:0] code = 5'h00;
  logic [6:0] adr = 7'h00;
  logic [2:0] bsel = 3'h0, page = 3'h2, ra = 3'h0;
  logic [7:0] imm = 8'h00, wd = 8'h00, rdat, acc, r;
  logic [3:0] flg;
  logic [10:0] ra_rom;
  logic [7:0] sa [4] = '{8'h50, 8'h30, 8'h80, 8'h42};
  logic [7:0] sb [4] = '{8'h30, 8'h50, 8'h01, 8'h42};
  logic [3:0] sx [4] = '{4'h3, 4'h2, 4'h9, 4'h7};
  int fail_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  skip_logic_table_read_ops dut_u (.CLK_IN(clk), .RST_IN(rst), .OP_VALID_IN(v), .OP_CODE_IN(code),
    .OP_ADDR_IN(adr), .OP_BIT_IN(bsel), .OP_IMM_IN(imm), .OP_PAGE_IN(page), .OP_READY_OUT(rdy),
    .OP_DONE_OUT(done), .OP_SKIP_OUT(skp), .ROM_ADDR_OUT(ra_rom),
    .ROM_DATA_IN({ra_rom[2:0], ra_rom[10:6], ra_rom[10:3]}), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .ACC_OUT(acc), .FLAGS_OUT(flg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rg(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 r = rdat;
  endtask
  task automatic ms(input logic [6:0] a, input logic [7:0] d);
    rg(1'b1, skip_pkg::REG_MEM_INDEX, {1'b0, a});
    rg(1'b1, skip_pkg::REG_MEM_DATA, d);
  endtask
  task automatic mg(input logic [6:0] a, input logic [7:0] e);
    rg(1'b1, skip_pkg::REG_MEM_INDEX, {1'b0, a});
    rg(1'b0, skip_pkg::REG_MEM_DATA, 8'h00);
    chk(r, e);
  endtask
  // Issues one operation, waits for done and checks skip and cycle count
  task automatic op(input logic [4:0] c, input logic [6:0] a, input logic [2:0] b, input logic [7:0] i,
      input logic sk);
    int n = 0;
    @(posedge clk);
    v <= 1'b1;
    code <= c;
    adr <= a;
    bsel <= b;
    imm <= i;
    @(posedge clk);
    v <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, skp}, {7'h00, sk});
    chk(n[7:0], {7'h00, sk | c == skip_pkg::OP_TBL_CUR | c == skip_pkg::OP_TBL_LAST});
  endtask
  task automatic t_regs;
    for (int k = 0; k < 8; k++) if (k != 5) begin
      rg(1'b0, k[2:0], 8'h00);
      chk(r, 8'h00);
    end
    rg(1'b1, skip_pkg::REG_UPPER, 8'hFF);
    rg(1'b0, skip_pkg::REG_UPPER, 8'h00);
    chk(r, 8'h00);
  endtask
  task automatic t_set;
    rg(1'b1, skip_pkg::REG_FLAGS, 8'h0A);
    ms(7'h0A, 8'h41);
    op(skip_pkg::OP_SET_BIT, 7'h0A, 3'h3, 8'h00, 1'b0);
    mg(7'h0A, 8'h49);
    op(skip_pkg::OP_SET_BYTE, 7'h0A, 3'h0, 8'h00, 1'b0);
    mg(7'h0A, 8'hFF);
  endtask
  task automatic t_inc;
    ms(7'h0B, 8'hFF);
    op(skip_pkg::OP_INC_SKIP, 7'h0B, 3'h0, 8'h00, 1'b1);
    mg(7'h0B, 8'h00);
    op(skip_pkg::OP_INC_SKIP, 7'h0B, 3'h0, 8'h00, 1'b0);
    mg(7'h0B, 8'h01);
    op(skip_pkg::OP_INC_ACC_SKIP, 7'h0B, 3'h0, 8'h00, 1'b0);
    chk(acc, 8'h02);
    ms(7'h0C, 8'hFF);
    op(skip_pkg::OP_INC_ACC_SKIP, 7'h0C, 3'h0, 8'h00, 1'b1);
    chk(acc, 8'h00);
    mg(7'h0C, 8'hFF);
  endtask
  task automatic t_skip;
    ms(7'h0D, 8'h10);
    op(skip_pkg::OP_SKIP_BIT_SET, 7'h0D, 3'h4, 8'h00, 1'b1);
    op(skip_pkg::OP_SKIP_BIT_SET, 7'h0D, 3'h3, 8'h00, 1'b0);
    op(skip_pkg::OP_SKIP_BIT_CLR, 7'h0D, 3'h3, 8'h00, 1'b1);
    op(skip_pkg::OP_SKIP_BIT_CLR, 7'h0D, 3'h4, 8'h00, 1'b0);
    op(skip_pkg::OP_SKIP_ZERO, 7'h0D, 3'h0, 8'h00, 1'b0);
    op(skip_pkg::OP_LOAD_ACC_SKIP, 7'h0D, 3'h0, 8'h00, 1'b0);
    chk(acc, 8'h10);
    ms(7'h0E, 8'h00);
    op(skip_pkg::OP_SKIP_ZERO, 7'h0E, 3'h0, 8'h00, 1'b1);
    op(skip_pkg::OP_LOAD_ACC_SKIP, 7'h0E, 3'h0, 8'h00, 1'b1);
    chk(acc, 8'h00);
    chk({4'h0, flg}, 8'h0A);
  endtask
  task automatic t_swap_tbl;
    ms(7'h10, 8'h3C);
    op(skip_pkg::OP_SWAP_ACC, 7'h10, 3'h0, 8'h00, 1'b0);
    chk(acc, 8'hC3);
    mg(7'h10, 8'h3C);
    op(skip_pkg::OP_SWAP_MEM, 7'h10, 3'h0, 8'h00, 1'b0);
    mg(7'h10, 8'hC3);
    rg(1'b1, skip_pkg::REG_LOOKUP_PTR, 8'h4B);
    op(skip_pkg::OP_TBL_CUR, 7'h11, 3'h0, 8'h00, 1'b0);
    mg(7'h11, 8'h49);
    rg(1'b0, skip_pkg::REG_UPPER, 8'h00);
    chk(r, 8'h69);
    @(posedge clk);
    page <= 3'h5;
    op(skip_pkg::OP_TBL_LAST, 7'h12, 3'h0, 8'h00, 1'b0);
    mg(7'h12, 8'hE9);
    rg(1'b0, skip_pkg::REG_UPPER, 8'h00);
    chk(r, 8'h7D);
    chk({4'h0, flg}, 8'h0A);
  endtask
  task automatic t_sub;
    for (int k = 0; k < 4; k++) begin
      rg(1'b1, skip_pkg::REG_ACC, sa[k]);
      op(skip_pkg::OP_SUB_IMM, 7'h00, 3'h0, sb[k], 1'b0);
      chk(acc, sa[k] - sb[k]);
      chk({4'h0, flg}, {4'h0, sx[k]});
    end
    ms(7'h13, 8'h30);
    rg(1'b1, skip_pkg::REG_ACC, 8'h50);
    op(skip_pkg::OP_SUB_ACC, 7'h13, 3'h0, 8'h00, 1'b0);
    chk(acc, 8'h20);
    chk({4'h0, flg}, 8'h03);
    rg(1'b1, skip_pkg::REG_ACC, 8'h30);
    op(skip_pkg::OP_SUB_MEM, 7'h13, 3'h0, 8'h00, 1'b0);
    mg(7'h13, 8'h00);
    chk({4'h0, flg}, 8'h07);
    chk(acc, 8'h30);
  endtask
  task automatic t_xor;
    rg(1'b1, skip_pkg::REG_FLAGS, 8'h09);
    ms(7'h14, 8'h5A);
    rg(1'b1, skip_pkg::REG_ACC, 8'h5A);
    op(skip_pkg::OP_XOR_ACC, 7'h14, 3'h0, 8'h00, 1'b0);
    chk({flg, acc[3:0]}, 8'hD0);
    op(skip_pkg::OP_XOR_IMM, 7'h00, 3'h0, 8'hFF, 1'b0);
    chk(acc, 8'hFF);
    op(skip_pkg::OP_XOR_MEM, 7'h14, 3'h0, 8'h00, 1'b0);
    mg(7'h14, 8'hA5);
    chk({flg, acc[3:0]}, 8'h9F);
    op(5'h1F, 7'h14, 3'h0, 8'h00, 1'b0);
    chk(acc, 8'hFF);
    chk({4'h0, flg}, 8'h09);
    mg(7'h14, 8'hA5);
  endtask
  task automatic final_report;
    $display("mismatches=%0d checks=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(100 * 4000);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_set();
    t_inc();
    t_skip();
    t_swap_tbl();
    t_sub();
    t_xor();
    final_report();
  end
endmodule
`default_nettype wire
